// ===== common/srs_pkg.sv
// Constants, register map and types of the system reset sequencer.
// Assumes a 100 MHz clock; all long times are kept in microseconds.
package srs_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_WD_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FS_CTRL = 8'h02;
  localparam logic [7:0] ADDR_WD_STAT = 8'h05;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h61;
  localparam logic [7:0] ADDR_STARTUP = 8'h73;
  // Field positions
  localparam int RCNT_LSB = 0;
  localparam int LIMP_BIT = 2;
  localparam int RLEN_LSB = 4;
  localparam int AUX_SUC_BIT = 3;
  localparam int HV4_BIT = 2;
  localparam int HV3_BIT = 1;
  localparam int HV2_BIT = 0;
  localparam int WD_MODE_LSB = 5;
  localparam int WD_PER_LSB = 0;
  localparam int WDI_BIT = 0;
  // Reset values
  localparam logic [7:0] FS_CTRL_RST = 8'h00;
  localparam logic [7:0] STARTUP_RST = 8'h00;
  localparam logic [7:0] WD_CTRL_RST = 8'h40;
  localparam logic [1:0] RCNT_MAX = 2'h3;
  // Watchdog mode and phase codes
  localparam logic [2:0] WD_MODE_WINDOW = 3'h4;
  localparam logic [2:0] WD_MODE_TIMEOUT = 3'h2;
  localparam logic [2:0] WD_MODE_AUTO = 3'h1;
  localparam logic [1:0] PH_OFF = 2'h0;
  localparam logic [1:0] PH_FIRST = 2'h1;
  localparam logic [1:0] PH_SECOND = 2'h2;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_US_NS = 1000;
  localparam int US_CYCLES = (T_US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RST_LEN0_US = 20000;
  localparam int T_RST_LEN1_US = 10000;
  localparam int T_RST_LEN2_US = 3600;
  localparam int T_RST_LEN3_US = 1000;
  localparam int T_RST_TO_US = 100000;
  localparam int T_WD_BASE_US = 8000;
  localparam int TMR_W = 18;
  // Sequencer states
  typedef enum logic [1:0] {ST_STANDBY, ST_RESET, ST_FAILSAFE} srs_state_t;
endpackage

// ===== common/srs_wd_if.sv
// Link between the sequencer core and its watchdog.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface srs_wd_if;
  logic tick;
  logic run;
  logic normal;
  logic irq_pending;
  logic ctrl_wr;
  logic [7:0] ctrl_data;
  logic trigger;
  logic flag_clr;
  logic [7:0] ctrl_q;
  logic [1:0] phase;
  logic flag;
  logic rst_req;
  modport ctrl (output tick, run, normal, irq_pending, ctrl_wr, ctrl_data, trigger, flag_clr,
                input ctrl_q, phase, flag, rst_req);
  modport wd (input tick, run, normal, irq_pending, ctrl_wr, ctrl_data, trigger, flag_clr,
              output ctrl_q, phase, flag, rst_req);
endinterface
`default_nettype wire

// ===== verification/srs_host_model.sv
// Host model sharing the open-drain reset line.
// Assumes the bench requests each pull with a one-cycle strobe.
`timescale 1ns/1ps
`default_nettype none
module srs_host_model (
  input wire logic i_clock,
  input wire logic i_dev_oe,
  input wire logic i_dev_data,
  input wire logic i_pull,
  output logic o_pin
);
  int hold_cnt = 0;
  // host holds the line low longer than the shortest pulse
  // Sampled on the rising edge, since the bench moves the strobe on the falling one
  always @(posedge i_clock) begin
    if (i_pull) hold_cnt <= 20;
    else if (hold_cnt > 0) hold_cnt <= hold_cnt - 1;
  end
  // open drain with pull-up, low if anyone drives
  assign o_pin = ((i_dev_oe && !i_dev_data) || hold_cnt > 0) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ===== verification/srs_top_tb_top.sv
// Bench for the reset sequencer with a host on the reset line.
// Assumes shortened times: 4 cycles a microsecond.
`timescale 1ns/1ps
`default_nettype none
module srs_top_tb_top;
  import srs_pkg::*;
  logic clock = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, nvm = 8'h1D;
  logic irq_n = 1'b1, sleep = 1'b0, lowp = 1'b0, pull = 1'b0, pin, oe;
  logic core_uv = 1'b0, bat_uv = 1'b0, normal = 1'b0, reg_sel = 1'b1, wd_trig = 1'b0, pin_out, flag;
  logic [1:0] ph;
  logic fs, limp, hv4, hv3, hv2;
  logic [1:0] count, aux;
  int n_fail = 0, compares = 0, n;
  // 100 MHz
  always #5 clock = ~clock;
  srs_top #(.P_CYC_PER_US(4), .P_RST_LEN0_US(40), .P_RST_LEN1_US(20), .P_RST_LEN2_US(8),
    .P_RST_LEN3_US(4), .P_RST_TO_US(200), .P_WD_BASE_US(16)) uut (
    .i_clock(clock), .i_sys_rst(sys_rst), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_nvm_startup(nvm),
    .i_core_uv(core_uv), .i_bat_uv(bat_uv), .i_reset_out_n_in(pin), .o_reset_out_n_out(pin_out),
    .o_reset_out_n_oe(oe), .i_normal_mode(normal), .i_leave_lowpower(lowp),
    .i_sleep_cmd(sleep), .i_irq_out_n(irq_n), .i_regular_irq_sel(reg_sel),
    .i_wdog_trigger(wd_trig), .o_reset_count(count), .o_wdog_phase_status(ph),
    .o_wdog_overflow_flag(flag), .o_fail_safe_state(fs), .o_limp_en(limp),
    .o_aux_reg_control(aux), .o_hv_pin4_fallback_en(hv4), .o_hv_pin3_fallback_en(hv3),
    .o_hv_pin2_fallback_en(hv2));
  srs_host_model host (.i_clock(clock), .i_dev_oe(oe), .i_dev_data(pin_out), .i_pull(pull), .o_pin(pin));
  task automatic close_out();
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Single-cycle strobes, launched and dropped on falling edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock) {reg_wr, addr, wdata} = {1'b1, a, d};
    @(negedge clock) reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock) {reg_rd, addr} = {1'b1, a};
    @(negedge clock) reg_rd = 1'b0;
    check(rdata, exp);
  endtask
  // Bounded wait for the pulse, then its length in cycles
  task automatic pulse(input int exp);
    int w;
    w = 0;
    n = 0;
    while (oe !== 1'b1 && w < 200) begin @(negedge clock); w++; end
    while (oe === 1'b1 && n < 400) begin @(negedge clock); n++; end
    // Never shorter than the selected length, at most a quarter longer
    check(8'(n >= exp && n <= exp + exp / 4), 8'h01);
  endtask
  task automatic s_power();
    pulse(80);
    wr(ADDR_WD_CTRL, 8'h20); // auto mode keeps the watchdog off outside normal mode while no interrupt is pending
    check({6'h00, count}, 8'h01);
    check({aux, 3'h0, hv4, hv3, hv2}, 8'hC5);
    rd(ADDR_STARTUP, 8'h1D);
  endtask
  task automatic s_pin();
    repeat (5) @(negedge clock);
    pull = 1'b1;
    @(negedge clock) pull = 1'b0;
    pulse(16);
    check({6'h00, count}, 8'h02);
  endtask
  task automatic s_clear();
    wr(ADDR_FS_CTRL, 8'h00);
    rd(ADDR_FS_CTRL, 8'h00);
    rd(8'h10, 8'h00);
  endtask
  task automatic trig();
    @(negedge clock) wd_trig = 1'b1;
    @(negedge clock) wd_trig = 1'b0;
  endtask
  // Timeout mode: period change quirks, double trigger, double overflow
  task automatic s_wdog();
    rd(ADDR_WD_STAT, 8'h00);
    wr(ADDR_WD_CTRL, 8'h41);
    wr(ADDR_WD_CTRL, 8'h41);
    wr(ADDR_IRQ_STAT, 8'h01);
    rd(ADDR_WD_STAT, 8'h01);
    repeat (40) @(negedge clock);
    wr(ADDR_WD_CTRL, 8'h40);
    check({6'h00, ph}, 8'h02);
    wr(ADDR_WD_CTRL, 8'h40);
    check({5'h00, flag, ph}, 8'h05);
    wr(ADDR_IRQ_STAT, 8'h01);
    check({5'h00, flag, ph}, 8'h01);
    trig();
    trig();
    check({6'h00, ph}, 8'h01);
    pulse(16);
    check({5'h00, flag, count}, 8'h05);
    wr(ADDR_WD_CTRL, 8'h20);
    wr(ADDR_IRQ_STAT, 8'h01);
  endtask
  // Supply monitors, time-out, leaving low power, refused normal-mode write
  task automatic s_uv();
    {core_uv, bat_uv} = 2'b11;
    repeat (40) @(negedge clock);
    check({5'h00, oe, count}, 8'h05);
    repeat (800) @(negedge clock);
    check({5'h00, oe, count}, 8'h06);
    {core_uv, bat_uv} = 2'b00;
    pulse(80);
    wr(ADDR_FS_CTRL, 8'h00);
    @(negedge clock) lowp = 1'b1;
    @(negedge clock) lowp = 1'b0;
    pulse(80);
    normal = 1'b1;
    wr(ADDR_WD_CTRL, 8'h41);
    pulse(16);
    normal = 1'b0;
    rd(ADDR_WD_CTRL, 8'h20);
    check({6'h00, count}, 8'h02);
  endtask
  task automatic s_failsafe();
    wr(ADDR_FS_CTRL, 8'h00);
    @(negedge clock) sleep = 1'b1;
    @(negedge clock) sleep = 1'b0;
    repeat (5) @(negedge clock);
    check({7'h00, oe}, 8'h00);
    for (int k = 1; k <= 4; k++) begin
      // Odd turns: interrupt pending; even turns: no regular source selected
      {irq_n, reg_sel} = (k % 2 == 1) ? 2'b01 : 2'b10;
      repeat (5) @(negedge clock);
      sleep = 1'b1;
      @(negedge clock) sleep = 1'b0;
      if (k < 4) pulse(16);
      if (k < 4) check({6'h00, count}, 8'(k));
    end
    repeat (5) @(negedge clock);
    check({4'h0, fs, limp, oe, pin}, 8'h0E);
    check({6'h00, count}, 8'h03);
  endtask
  // Hang guard, far beyond the few thousand cycles the run needs
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
  initial begin
    repeat (12) @(negedge clock);
    sys_rst = 1'b0;
    s_power();
    s_pin();
    s_clear();
    s_wdog();
    s_uv();
    s_failsafe();
    close_out();
  end
endmodule
`default_nettype wire

// ===== verilog/srs_top.sv
// System reset sequencer: reset sources, reset pulse, reset counter, fail-safe.
// Assumes register accesses arrive decoded from the serial port, one per cycle.
//
// What this block does
// - Writing watchdog control restarts timer in first half, phase 01, only outside normal mode; normal-mode writes reset.
// - Timeout mode shorter period may restart at second half, overflow comes early.
// - Period change in second half restarts first half; spurious overflow flag allowed.
// - Timeout trigger exactly at half restarts in second half, overflowing early.
// - Any system reset drives reset pin low and enters reset state, or fail-safe at count 3.
// - On entry increment counter below 3, then hold pin low for length.
// - Length timer expiry releases pin and moves to standby.
// - Counter at 3 on entry goes to fail-safe and enables limp-home.
// - Battery undervoltage blocks counter increment on reset entry.
// - Core undervoltage during reset restarts the length timer.
// - Time-out expiry increments counter, restarts below 3, else fail-safe.
// - Open-drain reset pin; external pull-down is a reset source.
// - Cold starts (power-up, core undervoltage, leaving low power) use the stored reset length field.
// - Other resets always use the shortest length, 1 to 1.5 ms.
// - Length field 5:4 selects 20, 10, 3.6 or 1 ms minimum.
// - Aux start-up bit loads aux regulator bits 00 or 11 at power-up.
// - Start-up bits 2,1,0 select limp-home on high-voltage pins 4,3,2.
// - Watchdog window overflow, early trigger, timeout double overflow cause reset.
// - Core undervoltage, normal-mode watchdog write, leaving low-power states cause reset.
// - Sleep command with pending or no regular interrupt causes reset.
// - Reset counter is bits 1:0 at address 02h, saturating at 3.
// - Watchdog phase: 00 off, 01 first half, 10 second half.
`timescale 1ns/1ps
`default_nettype none
module srs_top
  import srs_pkg::*;
#(
  parameter int P_CYC_PER_US = US_CYCLES,
  parameter int P_RST_LEN0_US = T_RST_LEN0_US,
  parameter int P_RST_LEN1_US = T_RST_LEN1_US,
  parameter int P_RST_LEN2_US = T_RST_LEN2_US,
  parameter int P_RST_LEN3_US = T_RST_LEN3_US,
  parameter int P_RST_TO_US = T_RST_TO_US,
  parameter int P_WD_BASE_US = T_WD_BASE_US
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic [7:0] i_nvm_startup,
  input wire logic i_core_uv,
  input wire logic i_bat_uv,
  input wire logic i_reset_out_n_in,
  output logic o_reset_out_n_out,
  output logic o_reset_out_n_oe,
  input wire logic i_normal_mode,
  input wire logic i_leave_lowpower,
  input wire logic i_sleep_cmd,
  input wire logic i_irq_out_n,
  input wire logic i_regular_irq_sel,
  input wire logic i_wdog_trigger,
  output logic [1:0] o_reset_count,
  output logic [1:0] o_wdog_phase_status,
  output logic o_wdog_overflow_flag,
  output logic o_fail_safe_state,
  output logic o_limp_en,
  output logic [1:0] o_aux_reg_control,
  output logic o_hv_pin4_fallback_en,
  output logic o_hv_pin3_fallback_en,
  output logic o_hv_pin2_fallback_en
);
  if (P_CYC_PER_US < 2 || P_RST_TO_US >= 2 ** TMR_W || P_RST_LEN0_US >= 2 ** TMR_W ||
      P_RST_LEN3_US < 1) begin : g_chk
    $error("Timing parameters out of range");
  end

  localparam int DIV_W = $clog2(P_CYC_PER_US);
  localparam logic [TMR_W-1:0] LEN3 = TMR_W'(P_RST_LEN3_US);
  localparam logic [TMR_W-1:0] TO_US = TMR_W'(P_RST_TO_US);

  srs_wd_if wdog_overflow_flag ();

  logic [DIV_W-1:0] div_r;
  logic tick;
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic core_uv_s;
  logic bat_uv_s;
  logic pin_s;
  srs_state_t state_r;
  logic drive_r;
  logic [2:0] drive_d_r;
  logic loaded_r;
  logic pwr_pend_r;
  logic [1:0] rcnt_r;
  logic [5:0] fs_upper_r;
  logic [7:0] startup_r;
  logic [1:0] aux_ctrl_r;
  logic fail_safe_r;
  logic [TMR_W-1:0] len_cnt_r;
  logic [TMR_W-1:0] len_us_r;
  logic [TMR_W-1:0] to_cnt_r;
  logic [7:0] rdata_r;
  logic fs_wr;
  logic wd_wr;
  logic ext_low;
  logic sleep_rst;
  logic cold;
  logic any_src;
  logic entry;
  logic to_fs;
  logic len_exp;
  logic to_exp;

  // Reset length in microseconds from the length field
  function automatic logic [TMR_W-1:0] rlen_us(input logic [1:0] sel);
    unique case (sel)
      2'h0: rlen_us = TMR_W'(P_RST_LEN0_US);
      2'h1: rlen_us = TMR_W'(P_RST_LEN1_US);
      2'h2: rlen_us = TMR_W'(P_RST_LEN2_US);
      2'h3: rlen_us = LEN3;
    endcase
  endfunction

  // Microsecond tick divider
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div_r <= '0;
    end else if (div_r == DIV_W'(P_CYC_PER_US - 1)) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end
  assign tick = (div_r == DIV_W'(P_CYC_PER_US - 1));

  // Two-stage synchronisers for the analogue monitors and the reset pin
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync1_r <= 3'h4;
      sync2_r <= 3'h4;
    end else begin
      sync1_r <= {i_reset_out_n_in, i_bat_uv, i_core_uv};
      sync2_r <= sync1_r;
    end
  end
  assign core_uv_s = sync2_r[0];
  assign bat_uv_s = sync2_r[1];
  assign pin_s = sync2_r[2];

  // Decoded accesses and reset sources
  always_comb begin
    fs_wr = i_reg_wr & (i_reg_addr == ADDR_FS_CTRL);
    wd_wr = i_reg_wr & (i_reg_addr == ADDR_WD_CTRL);
    // pin readback blanked while own drive settles
    ext_low = ~pin_s & ~drive_r & ~|drive_d_r;
    sleep_rst = i_sleep_cmd & (~i_irq_out_n | ~i_regular_irq_sel);
    cold = core_uv_s | i_leave_lowpower | pwr_pend_r;
    any_src = core_uv_s | ext_low | wdog_overflow_flag.rst_req | (wd_wr & i_normal_mode) | i_leave_lowpower |
              sleep_rst | pwr_pend_r;
    entry = loaded_r & (state_r == ST_STANDBY) & any_src;
    to_fs = (rcnt_r == RCNT_MAX);
    // A part tick leads, so count one more whole tick to keep the pulse at least the selected length
    len_exp = (state_r == ST_RESET) & tick & ~core_uv_s & (len_cnt_r >= len_us_r);
    to_exp = (state_r == ST_RESET) & tick & ~len_exp & (to_cnt_r + 1'b1 >= TO_US);
  end

  // Sequencer state and pin drive
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= ST_STANDBY;
      drive_r <= 1'b0;
      fail_safe_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_STANDBY: begin
          if (entry && to_fs) begin
            state_r <= ST_FAILSAFE;
            drive_r <= 1'b1;
            fail_safe_r <= 1'b1;
          end else if (entry) begin
            state_r <= ST_RESET;
            drive_r <= 1'b1;
          end
        end
        ST_RESET: begin
          if (len_exp) begin
            state_r <= ST_STANDBY;
            drive_r <= 1'b0;
          end else if (to_exp && to_fs) begin
            // give up after time-out at max count
            state_r <= ST_FAILSAFE;
            fail_safe_r <= 1'b1;
          end
        end
        ST_FAILSAFE: begin
          // Held until a power-on reset; the host pin stays low
          drive_r <= 1'b1;
        end
      endcase
    end
  end

  // Drive history, used to blank our own low level on the readback path
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      drive_d_r <= 3'h0;
    end else begin
      drive_d_r <= {drive_d_r[1:0], drive_r};
    end
  end

  // Pulse length and time-out timers
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      len_cnt_r <= '0;
      to_cnt_r <= '0;
      len_us_r <= LEN3;
    end else if (entry) begin
      len_cnt_r <= '0;
      to_cnt_r <= '0;
      len_us_r <= cold ? rlen_us(startup_r[RLEN_LSB +: 2]) : LEN3;
    end else if (state_r != ST_RESET || to_exp || core_uv_s) begin
      len_cnt_r <= '0;
      if (state_r != ST_RESET || to_exp) begin
        to_cnt_r <= '0;
      end else if (tick) begin
        to_cnt_r <= to_cnt_r + 1'b1;
      end
    end else if (tick) begin
      len_cnt_r <= len_cnt_r + 1'b1;
      to_cnt_r <= to_cnt_r + 1'b1;
    end
  end

  // Reset counter; hardware increments win over a host write
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rcnt_r <= FS_CTRL_RST[RCNT_LSB +: 2];
    end else if (entry && !to_fs && !bat_uv_s) begin
      rcnt_r <= rcnt_r + 2'h1;
    end else if (to_exp && !to_fs) begin
      // time-out counts as a further reset
      rcnt_r <= rcnt_r + 2'h1;
    end else if (fs_wr && state_r != ST_RESET) begin
      rcnt_r <= i_reg_wdata[RCNT_LSB +: 2];
    end
  end

  // Rest of the fail-safe control byte; limp bit forced on in fail-safe
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fs_upper_r <= FS_CTRL_RST[7:2];
    end else if (state_r == ST_FAILSAFE) begin
      fs_upper_r[LIMP_BIT-2] <= 1'b1;
    end else if (fs_wr) begin
      fs_upper_r <= i_reg_wdata[7:2];
    end
  end

  // Start-up byte taken from storage after reset; aux bits derived once
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      loaded_r <= 1'b0;
      pwr_pend_r <= 1'b1;
      startup_r <= STARTUP_RST;
      aux_ctrl_r <= 2'h0;
    end else if (!loaded_r) begin
      loaded_r <= 1'b1;
      startup_r <= {2'h0, i_nvm_startup[5:0]};
      aux_ctrl_r <= {2{i_nvm_startup[AUX_SUC_BIT]}};
    end else begin
      if (entry) begin
        pwr_pend_r <= 1'b0;
      end
      if (i_reg_wr && i_reg_addr == ADDR_STARTUP) begin
        startup_r <= {2'h0, i_reg_wdata[5:0]};
      end
    end
  end

  // Register read data, registered on the read strobe
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_r <= 8'h00;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        ADDR_WD_CTRL: rdata_r <= wdog_overflow_flag.ctrl_q;
        ADDR_FS_CTRL: rdata_r <= {fs_upper_r, rcnt_r};
        ADDR_WD_STAT: rdata_r <= {6'h00, wdog_overflow_flag.phase};
        ADDR_IRQ_STAT: rdata_r <= {7'h00, wdog_overflow_flag.flag};
        ADDR_STARTUP: rdata_r <= startup_r;
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  // Watchdog hookup; a write in normal mode is refused and resets instead
  assign wdog_overflow_flag.tick = tick;
  assign wdog_overflow_flag.run = (state_r == ST_STANDBY);
  assign wdog_overflow_flag.normal = i_normal_mode;
  assign wdog_overflow_flag.irq_pending = ~i_irq_out_n;
  assign wdog_overflow_flag.ctrl_wr = wd_wr & ~i_normal_mode;
  assign wdog_overflow_flag.ctrl_data = i_reg_wdata;
  assign wdog_overflow_flag.trigger = i_wdog_trigger;
  assign wdog_overflow_flag.flag_clr = i_reg_wr & (i_reg_addr == ADDR_IRQ_STAT) & i_reg_wdata[WDI_BIT];

  srs_wdog #(.P_WD_BASE_US(P_WD_BASE_US)) u_wdog (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .wd(wdog_overflow_flag.wd)
  );

  // Outputs
  assign o_reg_rdata = rdata_r;
  assign o_reset_out_n_out = 1'b0; // Open drain: only ever pulls low
  assign o_reset_out_n_oe = drive_r;
  assign o_reset_count = rcnt_r;
  assign o_wdog_phase_status = wdog_overflow_flag.phase;
  assign o_wdog_overflow_flag = wdog_overflow_flag.flag;
  assign o_fail_safe_state = fail_safe_r;
  assign o_limp_en = fs_upper_r[LIMP_BIT-2];
  assign o_aux_reg_control = aux_ctrl_r;
  assign o_hv_pin4_fallback_en = startup_r[HV4_BIT];
  assign o_hv_pin3_fallback_en = startup_r[HV3_BIT];
  assign o_hv_pin2_fallback_en = startup_r[HV2_BIT];

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  chk_entry_count_up: assert property (entry && !to_fs && !bat_uv_s |=> rcnt_r == $past(rcnt_r) + 2'h1)
    else $error("reset entry did not count");
  chk_bat_uv_hold: assert property (entry && bat_uv_s && !fs_wr |=> rcnt_r == $past(rcnt_r))
    else $error("counter moved under battery undervoltage");
  chk_max_failsafe: assert property (entry && to_fs |=> state_r == ST_FAILSAFE && o_reset_out_n_oe)
    else $error("count at max did not enter fail-safe");
  chk_pin_low_reset: assert property (state_r == ST_RESET |-> o_reset_out_n_oe)
    else $error("reset state without pin drive");
  chk_release_standby: assert property (len_exp |=> state_r == ST_STANDBY ##1 !o_reset_out_n_oe)
    else $error("pulse end did not release pin");
  chk_uv_restart_len: assert property (state_r == ST_RESET && core_uv_s && !entry |=> len_cnt_r == 0)
    else $error("core undervoltage did not restart pulse");
  chk_timeout_restart: assert property (to_exp && !to_fs |=> state_r == ST_RESET && to_cnt_r == 0)
    else $error("time-out did not restart sequence");
  chk_warm_short_len: assert property (entry && !cold |=> len_us_r == LEN3)
    else $error("warm reset not shortest length");
  chk_ext_pin_source: assert property (ext_low && state_r == ST_STANDBY && loaded_r |=> o_reset_out_n_oe)
    else $error("external pull-down not taken as reset");
  cov_reset_pulse: cover property (entry ##1 (state_r == ST_RESET) [*3]);
  cov_pulse_done: cover property (len_exp);
  cov_failsafe: cover property (state_r == ST_FAILSAFE);
  cov_timeout: cover property (to_exp);
endmodule
`default_nettype wire

// ===== verilog/srs_wdog.sv
// Watchdog timer with the restart quirks after control writes.
// Assumes a one-cycle microsecond tick and writes already gated by mode.
`timescale 1ns/1ps
`default_nettype none
module srs_wdog
  import srs_pkg::*;
#(
  parameter int P_WD_BASE_US = T_WD_BASE_US
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  srs_wd_if.wd wd
);
  if (P_WD_BASE_US * 16 >= 2 ** TMR_W) begin : g_chk
    $error("Watchdog base period too long for timer");
  end

  logic [2:0] mode_r;
  logic [3:0] per_r;
  logic [TMR_W-1:0] cnt_r;
  logic [1:0] phase_r;
  logic flag_r;
  logic rst_req_r;
  logic win;
  logic tmo;
  logic active;
  logic ovf;
  logic at_half;
  logic short_quirk;
  logic [3:0] new_per;

  // Period in microseconds from a period code
  function automatic logic [TMR_W-1:0] per_us(input logic [3:0] code);
    per_us = TMR_W'((int'(code) + 1) * P_WD_BASE_US);
  endfunction

  // Effective mode from the selection and the device mode
  always_comb begin
    win = wd.run & wd.normal & (mode_r == WD_MODE_WINDOW);
    tmo = wd.run & ((mode_r == WD_MODE_TIMEOUT) | ((mode_r == WD_MODE_WINDOW) & ~wd.normal) |
          ((mode_r == WD_MODE_AUTO) & (wd.normal | wd.irq_pending)));
    active = win | tmo;
    new_per = wd.ctrl_data[WD_PER_LSB +: 4];
    at_half = wd.tick & (cnt_r + 1'b1 == (per_us(per_r) >> 1));
    ovf = active & wd.tick & (phase_r != PH_OFF) & (cnt_r + 1'b1 >= per_us(per_r));
    // A shorter period that the elapsed time already passes half of
    short_quirk = tmo & (new_per < per_r) & (phase_r == PH_FIRST) & (cnt_r >= (per_us(new_per) >> 1));
  end

  // Control register
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_r <= WD_CTRL_RST[WD_MODE_LSB +: 3];
      per_r <= WD_CTRL_RST[WD_PER_LSB +: 4];
    end else if (wd.ctrl_wr) begin
      mode_r <= wd.ctrl_data[WD_MODE_LSB +: 3];
      per_r <= new_per;
    end
  end

  // Timer and phase
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_r <= '0;
      phase_r <= PH_OFF;
    end else if (!active) begin
      cnt_r <= '0;
      phase_r <= PH_OFF;
    end else if (wd.ctrl_wr) begin
      if (short_quirk) begin
        cnt_r <= per_us(new_per) >> 1;
        phase_r <= PH_SECOND;
      end else begin
        cnt_r <= '0;
        phase_r <= PH_FIRST;
      end
    end else if (phase_r == PH_OFF || ovf) begin
      cnt_r <= '0;
      phase_r <= PH_FIRST;
    end else if (wd.trigger && tmo && at_half) begin
      cnt_r <= cnt_r + 1'b1;
      phase_r <= PH_SECOND;
    end else if (wd.trigger) begin
      cnt_r <= '0;
      phase_r <= PH_FIRST;
    end else if (wd.tick) begin
      cnt_r <= cnt_r + 1'b1;
      if (at_half) begin
        phase_r <= PH_SECOND;
      end
    end
  end

  // Overflow flag; a set in the clearing cycle wins
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      flag_r <= 1'b0;
    end else if ((tmo && ovf) || (wd.ctrl_wr && tmo && phase_r == PH_SECOND)) begin
      flag_r <= 1'b1;
    end else if (wd.flag_clr) begin
      flag_r <= 1'b0;
    end
  end

  // Reset requests to the sequencer
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rst_req_r <= 1'b0;
    end else begin
      rst_req_r <= (win & ovf) | (tmo & ovf & flag_r) |
                   (win & wd.trigger & ~wd.ctrl_wr & (phase_r == PH_FIRST));
    end
  end

  assign wd.ctrl_q = {mode_r, 1'b0, per_r};
  assign wd.phase = phase_r;
  assign wd.flag = flag_r;
  assign wd.rst_req = rst_req_r;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  chk_wr_restart_first: assert property (wd.ctrl_wr && active && !short_quirk |=> phase_r == PH_FIRST && cnt_r == 0)
    else $error("control write did not restart watchdog");
  chk_short_second_half: assert property (wd.ctrl_wr && short_quirk |=> phase_r == PH_SECOND)
    else $error("shorter period did not land in second half");
  chk_early_trigger_rst: assert property (win && wd.trigger && !wd.ctrl_wr && phase_r == PH_FIRST |=> rst_req_r)
    else $error("early window trigger gave no reset");
  chk_half_trigger: assert property (tmo && wd.trigger && !wd.ctrl_wr && at_half && !ovf |=> phase_r == PH_SECOND)
    else $error("trigger at half did not stay in second half");
  cov_wd_overflow: cover property (tmo && ovf);
endmodule
`default_nettype wire
